// ---- src/pcr_busdiv.sv ----
// Purpose: divides core clock ticks into the bus clock
// Assumes: tick is a one-cycle enable at the core clock rate
// Notes:   held low and cleared while run is low
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defs.svh"
module pcr_busdiv (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       run,
  input  wire logic       tick,
  input  wire logic [1:0] ratio,
  output logic            bus_clk,
  output logic            bus_tick
);
  import pcr_pkg::*;

  pcr_div_t s;
  pcr_div_t next_s;

  // divisor minus one for each ratio code, unused 01 falls to a quarter
  function automatic logic [1:0] div_m1(input logic [1:0] r);
    case (r)
      `PCR_RATIO_HALF:  div_m1 = `PCR_DIV2_M1;
      `PCR_RATIO_THIRD: div_m1 = `PCR_DIV3_M1;
      default:          div_m1 = `PCR_DIV4_M1;
    endcase
  endfunction

  // count core ticks, high for the first half of each bus period, rounded down
  always_comb begin
    next_s = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s = '0;
    end else if (tick) begin
      next_s.cnt = (s.cnt >= div_m1(ratio)) ? 2'h0 : s.cnt + 2'h1;
      next_s.clk = ({1'b0, next_s.cnt} < ({1'b0, div_m1(ratio)} + 3'h1) >> 1);
      next_s.tick = (next_s.cnt == 2'h0);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus_clk  = s.clk;
  assign bus_tick = s.tick;

  a_div_range: assert property (@(posedge hclk) disable iff (!hresetn)
    run |-> s.cnt <= div_m1(ratio))
    else $error("bus divider count beyond divisor");
  a_div_half: assert property (@(posedge hclk) disable iff (!hresetn)
    (run && ratio == `PCR_RATIO_HALF && tick && s.cnt == 2'h1) |=> s.tick && s.clk)
    else $error("half ratio did not wrap after two ticks");
endmodule
`default_nettype wire

// ---- src/pcr_defs.svh ----
// Purpose: constants of the pll clock and reset control block
// Assumes: included by pcr_busdiv and pcr_top, not by the package
// Notes:   byte offsets on the ahb-lite register bus
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH
`define PCR_CTRL_OFF     8'h00
`define PCR_STAT_OFF     8'h04
`define PCR_PERMIT_BIT   7
`define PCR_LVL_HI       6
`define PCR_LVL_LO       4
`define PCR_CTRL_RST     8'h00
`define PCR_LOCK_CYCLES  100000
`define PCR_PRST_CYCLES  16
`define PCR_RATIO_QUART  2'b00
`define PCR_RATIO_HALF   2'b10
`define PCR_RATIO_THIRD  2'b11
`define PCR_DIV4_M1      2'h3
`define PCR_DIV2_M1      2'h1
`define PCR_DIV3_M1      2'h2
`define PCR_RATIO_LO     0
`define PCR_RATIO_HI     1
`define PCR_RANGE_LO     2
`define PCR_RANGE_HI     3
`endif

// ---- src/pcr_pkg.sv ----
// Purpose: types shared by the pll clock and reset control block
// Assumes: pcr_defs.svh holds the numeric constants
// Notes:   state codes are one-hot
package pcr_pkg;
  typedef enum logic [3:0] {
    PCR_RESET = 4'h1,
    PCR_LOCK  = 4'h2,
    PCR_RUN   = 4'h4,
    PCR_STOP  = 4'h8
  } pcr_state_t;

  // ahb-lite request and answer groups
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic        hready;
    logic [31:0] hwdata;
  } pcr_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } pcr_ahb_rsp_t;

  // whole state of the control module
  typedef struct packed {
    pcr_state_t  st;
    logic        ref_q;
    logic [7:0]  strap;
    logic [16:0] lock_cnt;
    logic [7:0]  prst_cnt;
    logic        permit;
    logic [2:0]  lvl;
    logic        a_valid;
    logic        a_write;
    logic [7:0]  a_addr;
    logic [31:0] hrdata;
    logic        stat_clk;
    logic        wake;
  } pcr_ctl_t;

  // whole state of the bus clock divider
  typedef struct packed {
    logic [1:0] cnt;
    logic       clk;
    logic       tick;
  } pcr_div_t;
endpackage

// ---- src/pcr_top.sv ----
// Purpose: clock, stop and reset control around a clock-multiplying loop
// Assumes: ref_clk_in and all inputs are synchronous to hclk (100 MHz)
// Notes:   clocks leave as one-cycle enables or registered levels
`timescale 1ns/1ps
`default_nettype none
`include "pcr_defs.svh"
module pcr_top #(
  parameter int LOCK_CYCLES = `PCR_LOCK_CYCLES,
  parameter int PRST_CYCLES = `PCR_PRST_CYCLES
) (
  input  wire logic                 hclk,
  input  wire logic                 hresetn,
  input  wire pcr_pkg::pcr_ahb_req_t ahb_req,
  output pcr_pkg::pcr_ahb_rsp_t     ahb_rsp,
  input  wire logic                 ext_reset_in_n,
  input  wire logic                 ref_clk_in,
  input  wire logic [7:0]           data_in,
  input  wire logic                 stop_req,
  input  wire logic [2:0]           irq_level,
  input  wire logic                 wdog_reset,
  output logic                      core_clk_en,
  output logic                      status_clk_out,
  output logic                      bus_clk_out,
  output logic                      bus_clk_tick,
  output logic                      periph_reset_out,
  output logic                      pll_hold_reset,
  output logic                      pll_locked,
  output logic [1:0]                input_range_strap,
  output logic [1:0]                bus_ratio,
  output logic                      core_wake
);
  import pcr_pkg::*;

  pcr_ctl_t    s;
  pcr_ctl_t    next_s;
  logic        ref_edge;
  logic        core_tick;
  logic        clocks_on;
  logic        bus_tick;
  logic        wake_ok;
  logic        req_take;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  // interrupt level reaches the programmed minimum
  function automatic logic level_wakes(input logic [2:0] code, input logic [2:0] lvl);
    case (code)
      3'h0:    level_wakes = (lvl != 3'h0);
      3'h1:    level_wakes = (lvl >= 3'h2);
      3'h2:    level_wakes = (lvl >= 3'h3);
      3'h3:    level_wakes = (lvl >= 3'h5);
      3'h4:    level_wakes = (lvl >= 3'h6);
      default: level_wakes = 1'b0;
    endcase
  endfunction

  // both reference edges make a core tick, twice the reference rate
  assign ref_edge  = ref_clk_in ^ s.ref_q;
  assign core_tick = ref_edge;
  assign clocks_on = (s.st == PCR_RUN) || (s.st == PCR_STOP);
  assign wake_ok   = level_wakes(s.lvl, irq_level);
  assign req_take  = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

  // bus clock keeps running through stop, held low until lock
  pcr_busdiv u_busdiv (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .run      (clocks_on),
    .tick     (core_tick),
    .ratio    (s.strap[`PCR_RATIO_HI:`PCR_RATIO_LO]),
    .bus_clk  (bus_clk_out),
    .bus_tick (bus_tick)
  );

  // register views
  always_comb begin
    ctrl_word = '0;
    ctrl_word[`PCR_PERMIT_BIT] = s.permit;
    ctrl_word[`PCR_LVL_HI:`PCR_LVL_LO] = s.lvl;
    stat_word = '0;
    stat_word[7:0] = s.strap;
    stat_word[11:8] = s.st;
    stat_word[12] = pll_locked;
    stat_word[13] = periph_reset_out;
  end

  // main sequencing, register bus and clock outputs
  always_comb begin
    next_s = s;
    next_s.ref_q = ref_clk_in;
    next_s.wake = 1'b0;
    next_s.stat_clk = core_tick && (s.st == PCR_RUN);
    case (s.st)
      PCR_RESET: begin
        next_s.st = PCR_LOCK;
        next_s.lock_cnt = '0;
      end
      PCR_LOCK: begin
        if (ref_clk_in && !s.ref_q) begin
          if (s.lock_cnt == 17'(LOCK_CYCLES - 1)) begin
            next_s.st = PCR_RUN;
            next_s.prst_cnt = '0;
          end else begin
            next_s.lock_cnt = s.lock_cnt + 17'h1;
          end
        end
      end
      PCR_RUN: begin
        if (bus_tick && s.prst_cnt != 8'(PRST_CYCLES)) begin
          next_s.prst_cnt = s.prst_cnt + 8'h1;
        end
        if (stop_req && s.permit) begin
          next_s.st = PCR_STOP;
        end
      end
      PCR_STOP: begin
        if (bus_tick && s.prst_cnt != 8'(PRST_CYCLES)) begin
          next_s.prst_cnt = s.prst_cnt + 8'h1;
        end
        if (wake_ok || wdog_reset) begin
          next_s.st = PCR_RUN;
          next_s.wake = 1'b1;
        end
      end
      default: begin
        next_s.st = PCR_RESET;
      end
    endcase
    // ahb data phase: write to the control register
    if (s.a_valid && s.a_write && s.a_addr == `PCR_CTRL_OFF) begin
      next_s.permit = ahb_req.hwdata[`PCR_PERMIT_BIT];
      next_s.lvl = ahb_req.hwdata[`PCR_LVL_HI:`PCR_LVL_LO];
    end
    // external reset overrides sequencing and control writes and samples the straps
    if (!ext_reset_in_n) begin
      next_s.st = PCR_RESET;
      next_s.strap = data_in;
      next_s.lock_cnt = '0;
      next_s.prst_cnt = '0;
      next_s.permit = 1'(`PCR_CTRL_RST >> `PCR_PERMIT_BIT);
      next_s.lvl = '0;
      next_s.stat_clk = 1'b0;
    end
    // ahb address phase
    next_s.a_valid = req_take;
    next_s.a_write = ahb_req.hwrite;
    next_s.a_addr = ahb_req.haddr[7:0];
    if (req_take && !ahb_req.hwrite) begin
      case (ahb_req.haddr[7:0])
        `PCR_CTRL_OFF: next_s.hrdata = ctrl_word;
        `PCR_STAT_OFF: next_s.hrdata = stat_word;
        default:       next_s.hrdata = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.st <= PCR_RESET;
    end else begin
      s <= next_s;
    end
  end

  // outputs
  assign core_clk_en       = core_tick && (s.st == PCR_RUN);
  assign status_clk_out    = s.stat_clk;
  assign bus_clk_tick      = bus_tick;
  assign pll_hold_reset    = (s.st == PCR_RESET);
  assign pll_locked        = clocks_on;
  assign periph_reset_out  = !clocks_on || (s.prst_cnt != 8'(PRST_CYCLES));
  assign input_range_strap = s.strap[`PCR_RANGE_HI:`PCR_RANGE_LO];
  assign bus_ratio         = s.strap[`PCR_RATIO_HI:`PCR_RATIO_LO];
  assign core_wake         = s.wake;
  assign ahb_rsp.hrdata    = s.hrdata;
  assign ahb_rsp.hreadyout = 1'b1;
  assign ahb_rsp.hresp     = 1'b0;

  // checks
  a_strap_capture: assert property (@(posedge hclk) disable iff (!hresetn)
    !ext_reset_in_n |=> s.strap == $past(data_in))
    else $error("strap not sampled during reset");
  a_strap_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    (ext_reset_in_n && $past(ext_reset_in_n)) |=> $stable(s.strap))
    else $error("strap changed outside reset");
  a_pll_held: assert property (@(posedge hclk) disable iff (!hresetn)
    !ext_reset_in_n |=> pll_hold_reset && !pll_locked)
    else $error("loop not held in reset");
  a_clocks_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (!clocks_on && !$past(clocks_on)) |-> !bus_clk_out && !status_clk_out)
    else $error("output clock ran before lock");
  a_lock_count: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == PCR_LOCK && next_s.st == PCR_RUN) |-> s.lock_cnt == 17'(LOCK_CYCLES - 1))
    else $error("lock declared at wrong count");
  a_prst_mode: assert property (@(posedge hclk) disable iff (!hresetn)
    s.st == PCR_RESET |-> periph_reset_out ##1 periph_reset_out)
    else $error("peripheral reset low in reset mode");
  a_prst_release: assert property (@(posedge hclk) disable iff (!hresetn)
    $fell(periph_reset_out) |-> clocks_on && s.prst_cnt == 8'(PRST_CYCLES))
    else $error("peripheral reset released early");
  a_stop_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == PCR_RUN && stop_req && !s.permit && ext_reset_in_n) |=> s.st == PCR_RUN)
    else $error("stop taken without permit");
  a_stop_gates: assert property (@(posedge hclk) disable iff (!hresetn)
    s.st == PCR_STOP |-> !core_clk_en && pll_locked)
    else $error("core clock ran during stop");
  a_wake_level: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == PCR_STOP && ext_reset_in_n && level_wakes(s.lvl, irq_level)) |=> s.st == PCR_RUN && core_wake)
    else $error("qualified interrupt did not wake");
  a_wake_low: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == PCR_STOP && s.lvl > 3'h4 && !wdog_reset && ext_reset_in_n) |=> s.st == PCR_STOP)
    else $error("unlisted wake code let an interrupt wake");
  a_reset_wakes: assert property (@(posedge hclk) disable iff (!hresetn)
    (s.st == PCR_STOP && wdog_reset && ext_reset_in_n) |=> s.st == PCR_RUN && pll_locked)
    else $error("watchdog reset did not end stop");
  a_core_rate: assert property (@(posedge hclk) disable iff (!hresetn)
    core_clk_en |-> ref_clk_in != $past(ref_clk_in))
    else $error("core tick without reference edge");

  c_stop_entered: cover property (@(posedge hclk) disable iff (!hresetn)
    s.st == PCR_RUN ##1 s.st == PCR_STOP);
  c_irq_wake: cover property (@(posedge hclk) disable iff (!hresetn)
    s.st == PCR_STOP && !wdog_reset ##1 core_wake);
  c_locked: cover property (@(posedge hclk) disable iff (!hresetn)
    $rose(pll_locked));
  c_prst_done: cover property (@(posedge hclk) disable iff (!hresetn)
    $fell(periph_reset_out));
endmodule
`default_nettype wire

// ---- tb/pcr_board.sv ----
// Purpose: board model giving the reference clock, device reset and straps
// Assumes: reference runs at a quarter of hclk and is never retuned
// Notes:   data lines show the inverse strap once reset is released
`timescale 1ns/1ps
`default_nettype none
module pcr_board (
  input  wire logic       hclk,
  input  wire logic       go,
  input  wire logic [7:0] strap,
  output logic            ref_clk_in,
  output logic            ext_reset_in_n,
  output logic [7:0]      data_in
);
  logic ph = 1'b0;

  // steady 25 mhz reference, same rate for the whole run
  initial ref_clk_in = 1'b0;
  always @(posedge hclk) begin
    ph <= ~ph;
    if (ph) begin
      ref_clk_in <= ~ref_clk_in;
    end
  end

  // device reset of 80 reference cycles with straps on the data lines
  initial begin
    ext_reset_in_n = 1'b1;
    data_in = 8'h00;
    forever begin
      @(posedge hclk);
      if (go) begin
        ext_reset_in_n <= 1'b0;
        data_in <= strap;  // range code 00 suits a 25 mhz reference
        repeat (80) @(posedge ref_clk_in);
        @(posedge hclk);
        ext_reset_in_n <= 1'b1;
        data_in <= ~strap;
      end
    end
  end
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the clock, stop and reset control
// Assumes: board model drives the reference clock, device reset and straps
// Notes:   lock and peripheral reset counts are shortened
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pcr_pkg::*;
  localparam int          LK = 8;
  localparam int          PR = 2;
  localparam logic [23:0] ST = {8'h53, 8'hc2, 8'h30};
  localparam logic [11:0] DV = {4'd3, 4'd2, 4'd4};
  localparam logic [23:0] LO = {3'd7, 3'd7, 3'd7, 3'd5, 3'd4, 3'd2, 3'd1, 3'd0};
  localparam logic [23:0] HI = {3'd7, 3'd7, 3'd7, 3'd6, 3'd5, 3'd3, 3'd2, 3'd1};
  logic         hclk = 1'b0;
  logic         hresetn = 1'b0;
  pcr_ahb_req_t req = '0;
  pcr_ahb_rsp_t rsp;
  logic         ref_clk_in, ext_reset_in_n, core_clk_en, status_clk_out;
  logic         bus_clk_out, bus_clk_tick, periph_reset_out, pll_hold_reset;
  logic         pll_locked, core_wake;
  logic         go = 1'b0;
  logic         stop_req = 1'b0;
  logic         wdog_reset = 1'b0;
  logic [2:0]   irq_level = 3'h0;
  logic [7:0]   data_in;
  logic [7:0]   strap = 8'h00;
  logic [1:0]   input_range_strap, bus_ratio;
  logic [31:0]  rd;
  int           failures = 0;
  int           cmp_count = 0;
  int           g;

  // clock, and hready looped back from the one slave
  always #5 hclk = ~hclk;
  always @* req.hready = rsp.hreadyout;

  pcr_top #(.LOCK_CYCLES(LK), .PRST_CYCLES(PR)) i_pcr_top (
    .hclk(hclk), .hresetn(hresetn), .ahb_req(req), .ahb_rsp(rsp),
    .ext_reset_in_n(ext_reset_in_n), .ref_clk_in(ref_clk_in), .data_in(data_in),
    .stop_req(stop_req), .irq_level(irq_level), .wdog_reset(wdog_reset),
    .core_clk_en(core_clk_en), .status_clk_out(status_clk_out), .bus_clk_out(bus_clk_out),
    .bus_clk_tick(bus_clk_tick), .periph_reset_out(periph_reset_out),
    .pll_hold_reset(pll_hold_reset), .pll_locked(pll_locked),
    .input_range_strap(input_range_strap), .bus_ratio(bus_ratio), .core_wake(core_wake)
  );
  pcr_board i_pcr_board (.hclk(hclk), .go(go), .strap(strap), .ref_clk_in(ref_clk_in),
    .ext_reset_in_n(ext_reset_in_n), .data_in(data_in));

  // compare and report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic end_of_test;
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one single ahb-lite word transfer; read data land in rd
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    req.hsel <= 1'b1;
    req.htrans <= 2'b10;
    req.haddr <= {24'h0, a};
    req.hwrite <= wr;
    req.hsize <= 3'h2;
    do @(posedge hclk); while (req.hready !== 1'b1);
    req.hsel <= 1'b0;
    req.htrans <= 2'b00;
    req.hwdata <= d;
    do @(posedge hclk); while (req.hready !== 1'b1);
    rd = rsp.hrdata;
  endtask

  // cycles between two pulses of the core (sel 1) or bus clock enable
  task automatic span(input logic sel);
    g = 0;
    do @(negedge hclk); while ((sel ? core_clk_en : bus_clk_tick) !== 1'b1);
    do begin
      @(negedge hclk);
      g++;
    end while ((sel ? core_clk_en : bus_clk_tick) !== 1'b1 && g < 40);
  endtask

  // one-cycle stop instruction from the core
  task automatic pulse_stop;
    @(posedge hclk);
    stop_req <= 1'b1;
    @(posedge hclk);
    stop_req <= 1'b0;
  endtask

  // device reset with straps, then lock wait and peripheral reset count
  task automatic board(input logic [7:0] s);
    @(posedge hclk);
    strap <= s;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    do @(negedge hclk); while (ext_reset_in_n !== 1'b0);
    @(negedge hclk);
    chk("loop held", pll_hold_reset, 1);
    chk("periph reset", periph_reset_out, 1);
    do @(negedge hclk); while (ext_reset_in_n !== 1'b1);
    g = 0;
    while (pll_locked !== 1'b1 && g < 99) begin
      chk("clocks low", {bus_clk_out, status_clk_out}, 0);
      @(negedge hclk);
      g++;
    end
    chk("lock time", g >= LK * 4 - 4 && g <= LK * 4 + 6, 1);
    g = 0;
    while (periph_reset_out === 1'b1 && g < 99) begin
      g += bus_clk_tick;
      @(negedge hclk);
    end
    chk("periph ticks", g, PR);
    chk("straps", {input_range_strap, bus_ratio}, s[3:0]);
    ahb(1'b0, 8'h04, 0);
    chk("status", rd[13:0], {2'b01, 4'h4, s});
    ahb(1'b0, 8'h00, 0);
    chk("ctrl reset", rd, 0);
  endtask

  // stop at a wake level, an interrupt too low, then the waking event
  task automatic stop_wake(input logic [2:0] lvl, input logic [2:0] lo, input logic [2:0] hi);
    ahb(1'b1, 8'h00, {24'h0, 1'b1, lvl, 4'h0});
    irq_level <= lo;
    pulse_stop();
    g = 0;
    // status clock may still echo the last core pulse taken before stop
    @(negedge hclk);
    chk("core gated", {core_clk_en, core_wake, pll_locked}, 1);
    repeat (12) begin
      @(negedge hclk);
      g += bus_clk_tick;
      chk("core gated", {core_clk_en, status_clk_out, core_wake, pll_locked}, 1);
    end
    chk("bus runs", g > 0, 1);
    @(posedge hclk);
    irq_level <= hi;
    wdog_reset <= lvl > 3'h4;
    @(posedge hclk);
    wdog_reset <= 1'b0;
    irq_level <= 3'h0;
    g = 0;
    repeat (3) begin
      @(negedge hclk);
      g += core_wake;
    end
    chk("wake", g, 1);
    span(1'b1);
    chk("core back", g, 2);
  endtask

  // main sequence
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 8'h00, 0);
    chk("ctrl reset", rd, 0);
    ahb(1'b1, 8'h00, 32'hffff_ffff);
    ahb(1'b0, 8'h00, 0);
    chk("ctrl rw", rd, 32'hf0);
    ahb(1'b1, 8'h08, 32'hffff_ffff);
    ahb(1'b0, 8'h08, 0);
    chk("unmapped", rd, 0);
    for (int i = 0; i < 3; i++) begin
      board(ST[i*8+:8]);
      span(1'b0);
      chk("bus ratio", g, 2 * DV[i*4+:4]);
    end
    ahb(1'b1, 8'h00, 32'h70);
    pulse_stop();
    span(1'b1);
    chk("no stop", g, 2);
    repeat (8) begin
      @(negedge hclk);
      rd[0] = core_clk_en;
      @(negedge hclk);
      chk("status clk", status_clk_out, rd[0]);
    end
    for (int l = 0; l < 8; l++) begin
      stop_wake(3'(l), LO[l*3+:3], HI[l*3+:3]);
    end
    ahb(1'b1, 8'h00, 32'h80);
    pulse_stop();
    board(8'h30);  // device reset ends stop with a full relock
    end_of_test();
  end

  // hang guard well beyond the expected run length
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    end_of_test();
  end
endmodule
`default_nettype wire
